// ==== hw/ccd_decoder.sv ====
`default_nettype none
module ccd_decoder (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr_word,
    input  wire logic [3:0]  rep_reg_value,
    input  wire logic        carry_status,
    output logic             instr_ready,
    output logic             done,
    output logic [1:0]       done_len,
    output logic             ext_addr20,
    output logic             ext_noprefix,
    output logic [1:0]       width_sel,
    output logic             carry_force_select,
    output logic             carry_use,
    output logic [3:0]       rep_reg_sel,
    output logic [3:0]       src_hi,
    output logic [3:0]       dst_hi,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [3:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp
);
    import ccd_pkg::*;

    logic [1:0]  rst_sync;
    logic        rst_sync_n;
    ccd_state_t  state;
    logic        ext_held;
    logic [15:0] ext_word;
    logic        ext_regmode;
    logic [2:0]  cyc_left;
    logic [3:0]  rep_left;
    logic [2:0]  cur_cyc;
    logic        ctrl_en;
    logic [2:0]  last_cyc;
    logic [3:0]  last_rep;
    logic [31:0] retired;
    logic        is_ext;
    logic        accept;
    logic        is_jump;
    logic        is_fmt1;
    logic        is_fmt2;
    logic        src_cg;
    logic        short_op;
    logic        dst_mem;
    logic        dst_pc;
    logic        reg_layout;
    logic [2:0]  dec_cyc;
    logic [1:0]  dec_len;
    logic [3:0]  dec_rep;
    logic [1:0]  as_mode;
    logic [3:0]  src_reg;
    logic        aw_held;
    logic        w_held;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;

    // Reset is released through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_sync[1];

    assign as_mode = instr_word[5:4];
    assign src_reg = instr_word[11:8];
    assign accept  = instr_valid && instr_ready;
    assign is_ext  = instr_word[EXT_OP_HI:EXT_OP_LO] == EXT_OPCODE;
    assign is_jump = instr_word[15:13] == JUMP_OPCODE;
    assign is_fmt1 = instr_word[15:14] != FMT1_NONE;
    assign is_fmt2 = instr_word[15:10] == FMT2_OPCODE;
    // Constant generators time like a register source
    assign src_cg  = (src_reg == REG_CG)
                     || (src_reg == REG_SR && as_mode[1]);
    assign dst_mem = instr_word[AD_BIT];
    assign dst_pc  = !dst_mem && instr_word[3:0] == REG_PC;
    assign short_op = instr_word[15:12] == OP_MOV
                      || instr_word[15:12] == OP_BIT
                      || instr_word[15:12] == OP_CMP;
    // Register layout only when no operand touches memory
    assign reg_layout = (is_fmt1 && as_mode == AS_REG && !dst_mem)
                        || (is_fmt2 && as_mode == AS_REG);

    always_comb begin
        dec_cyc = CYC_1;
        dec_len = LEN_1;
        if (is_jump) begin
            dec_cyc = CYC_2;
            dec_len = LEN_1;
        end else if (is_fmt1) begin
            if (as_mode == AS_REG || src_cg) begin
                dec_cyc = dst_mem ? CYC_4 : (dst_pc ? CYC_2 : CYC_1);
                dec_len = dst_mem ? LEN_2 : LEN_1;
            end else if (as_mode == AS_IDX) begin
                dec_cyc = dst_mem ? CYC_6 : CYC_3;
                dec_len = dst_mem ? LEN_3 : LEN_2;
            end else if (as_mode == AS_INC && src_reg == REG_PC) begin
                dec_cyc = dst_mem ? CYC_5 : (dst_pc ? CYC_3 : CYC_2);
                dec_len = dst_mem ? LEN_3 : LEN_2;
            end else begin
                dec_cyc = dst_mem ? CYC_5 : (dst_pc ? CYC_3 : CYC_2);
                dec_len = dst_mem ? LEN_2 : LEN_1;
            end
            if (dst_mem && short_op) begin
                dec_cyc = dec_cyc - CYC_1;
            end
        end
    end

    // Field holds n-1; the source is the prefix or a register
    always_comb begin
        dec_rep = 4'h0;
        if (ext_held && ext_regmode && reg_layout) begin
            dec_rep = ext_word[EXT_REP_BIT] ? rep_reg_value
                                            : ext_word[3:0];
        end
    end

    // Prefix capture; bits 10:9 are never looked at in register layout
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ext_held    <= 1'b0;
            ext_word    <= 16'h0000;
            ext_regmode <= 1'b0;
        end else if (accept && is_ext) begin
            ext_held    <= 1'b1;
            ext_word    <= instr_word;
            ext_regmode <= 1'b1;
        end else if (accept && ext_held) begin
            // Spent at its own accept, so a word taken in the done
            // cycle is never mistaken for a prefixed one
            ext_held    <= 1'b0;
            ext_regmode <= reg_layout;
        end else if (done) begin
            ext_held    <= 1'b0;
            ext_regmode <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state       <= CCD_IDLE;
            instr_ready <= 1'b0;
            done        <= 1'b0;
            done_len    <= LEN_1;
            cyc_left    <= CYC_1;
            rep_left    <= 4'h0;
            cur_cyc     <= CYC_1;
        end else begin
            done <= 1'b0;
            unique case (state)
                CCD_IDLE: begin
                    instr_ready <= ctrl_en;
                    if (accept && !is_ext) begin
                        state       <= CCD_EXEC;
                        instr_ready <= 1'b0;
                        cyc_left    <= dec_cyc;
                        cur_cyc     <= dec_cyc;
                        rep_left    <= dec_rep;
                        done_len    <= dec_len;
                    end
                end
                CCD_EXEC: begin
                    if (cyc_left != CYC_1) begin
                        cyc_left <= cyc_left - CYC_1;
                    end else if (rep_left != 4'h0) begin
                        rep_left <= rep_left - 4'h1;
                        cyc_left <= cur_cyc;
                    end else begin
                        done        <= 1'b1;
                        state       <= CCD_IDLE;
                        instr_ready <= ctrl_en;
                    end
                end
            endcase
        end
    end

    // Qualifiers seen by execute while the instruction runs
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ext_addr20   <= 1'b0;
            ext_noprefix <= 1'b0;
            width_sel    <= WIDTH_WORD;
            src_hi       <= 4'h0;
            dst_hi       <= 4'h0;
        end else if (accept && !is_ext) begin
            ext_addr20   <= ext_held;
            // Opcode group 0 holds extended forms with no prefix
            ext_noprefix <= instr_word[15:12] == 4'h0 && !is_fmt2;
            width_sel    <= {ext_held ? ext_word[EXT_AL_BIT] : 1'b1,
                             instr_word[BW_BIT]};
            src_hi <= ext_held && !reg_layout
                      ? ext_word[EXT_SRC_HI:EXT_SRC_LO] : 4'h0;
            dst_hi <= ext_held && !reg_layout ? ext_word[3:0] : 4'h0;
        end else if (done) begin
            ext_addr20 <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            carry_force_select <= 1'b0;
            rep_reg_sel        <= 4'h0;
            carry_use          <= 1'b0;
        end else begin
            if (accept && is_ext) begin
                carry_force_select <= instr_word[EXT_CF_BIT];
                rep_reg_sel        <= instr_word[3:0];
            end else if (accept && !reg_layout) begin
                // Only the register layout has a carry-force bit
                carry_force_select <= 1'b0;
            end else if (done) begin
                carry_force_select <= 1'b0;
            end
            carry_use <= carry_force_select ? 1'b0 : carry_status;
        end
    end

    // Register file: control steers acceptance, status shows state
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl_en  <= CTRL_RESET;
            last_cyc <= CYC_1;
            last_rep <= 4'h0;
            retired  <= 32'h0000_0000;
        end else begin
            if (aw_held && w_held && !s_axi_bvalid
                && aw_addr == ADDR_CTRL && w_strb[0]) begin
                ctrl_en <= w_data[0];
            end
            if (accept && !is_ext) begin
                last_cyc <= dec_cyc;
                last_rep <= dec_rep;
            end
            if (done) begin
                retired <= retired + 32'h0000_0001;
            end
        end
    end

    // Address and data may arrive in either order
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 4'h0;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready;
            s_axi_wready  <= !w_held && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= aw_addr[1:0] == 2'h0 ? RESP_OKAY
                                                     : RESP_DECERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_held       <= 1'b0;
                w_held        <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready  <= 1'b0;
            end
        end
    end

    always_comb begin
        next_rresp = RESP_OKAY;
        next_rdata = 32'h0000_0000;
        unique case (s_axi_araddr)
            ADDR_CTRL:    next_rdata = {31'h0, ctrl_en};
            ADDR_STATUS:  next_rdata = {26'h0, width_sel, carry_force_select,
                                        ext_held, state == CCD_EXEC,
                                        ext_addr20};
            ADDR_LAST:    next_rdata = {22'h0, done_len, last_rep, 1'b0,
                                        last_cyc};
            ADDR_RETIRED: next_rdata = retired;
            default:      next_rresp = RESP_DECERR;
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= next_rdata;
                s_axi_rresp   <= next_rresp;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_sync_n);

    jump_timing_a: assert property (
        accept && !ext_held && is_jump |-> ##3 done && done_len == LEN_1)
        else $error("jump not done in two cycles");
    reg_dst_a: assert property (
        accept && !ext_held && is_fmt1 && as_mode == AS_REG && !src_cg
        && !dst_mem && !dst_pc |-> ##2 done && done_len == LEN_1)
        else $error("register move not done in one cycle");
    pc_dst_a: assert property (
        accept && !ext_held && is_fmt1 && as_mode == AS_REG && dst_pc
        |-> ##1 !done ##2 done)
        else $error("register to pc not done in two cycles");
    ind_mem_a: assert property (
        accept && is_fmt1 && !src_cg && dst_mem && !short_op
        && (as_mode == AS_IND || (as_mode == AS_INC && src_reg != REG_PC))
        |-> ##6 done && done_len == LEN_2)
        else $error("indirect to memory timing wrong");
    imm_mem_a: assert property (
        accept && is_fmt1 && as_mode == AS_INC && src_reg == REG_PC
        && dst_mem && !short_op |-> ##6 done && done_len == LEN_3)
        else $error("immediate to memory timing wrong");
    idx_mem_a: assert property (
        accept && is_fmt1 && as_mode == AS_IDX && !src_cg && dst_mem
        && !short_op |-> ##7 done && done_len == LEN_3)
        else $error("indexed to memory timing wrong");
    short_op_a: assert property (
        accept && is_fmt1 && as_mode == AS_IDX && !src_cg && dst_mem
        && short_op |-> ##6 done)
        else $error("move to memory not one cycle shorter");
    ext_detect_a: assert property (
        accept && is_ext |=> ext_held && instr_ready && !done)
        else $error("prefix word not held");
    addr_wide_a: assert property (
        accept && !is_ext && ext_held |=> ext_addr20)
        else $error("prefixed instruction not 20-bit");
    carry_zero_a: assert property (
        carry_force_select && $past(carry_force_select) |-> !carry_use)
        else $error("forced carry not zero");
    carry_pass_a: assert property (
        !carry_force_select && !$past(carry_force_select)
        |-> carry_use == $past(carry_status))
        else $error("status carry not passed");
    repeat_cnt_a: assert property (
        accept && ext_held && ext_regmode && reg_layout && !dst_pc
        && !ext_word[EXT_REP_BIT] && ext_word[3:0] == 4'h3
        |-> ##4 !done ##1 done)
        else $error("repeat count from prefix wrong");
    repeat_reg_a: assert property (
        accept && ext_held && ext_regmode && reg_layout && !dst_pc
        && ext_word[EXT_REP_BIT] && rep_reg_value == 4'h3
        |-> ##4 !done ##1 done)
        else $error("repeat count from register wrong");
    width_code_a: assert property (
        accept && !is_ext && ext_held
        |=> width_sel == {$past(ext_word[EXT_AL_BIT]),
                          $past(instr_word[BW_BIT])})
        else $error("operand width wrong");
    ext_drop_a: assert property (
        done && !(accept && is_ext) |=> !ext_held)
        else $error("prefix kept past its instruction");

    jump_seen_c: cover property (accept && is_jump ##3 done);
    repeat_seen_c: cover property (accept && ext_held && rep_left == 4'h0
                                   ##1 rep_left != 4'h0);
    short_seen_c: cover property (accept && dst_mem && short_op);
endmodule
`default_nettype wire

// ==== hw/ccd_pkg.sv ====
`default_nettype none
package ccd_pkg;
    // Instruction word fields
    localparam logic [4:0] EXT_OPCODE   = 5'h03;
    localparam logic [2:0] JUMP_OPCODE  = 3'h1;
    localparam logic [5:0] FMT2_OPCODE  = 6'h04;
    localparam logic [1:0] FMT1_NONE    = 2'h0;
    localparam logic [3:0] OP_MOV       = 4'h4;
    localparam logic [3:0] OP_CMP       = 4'h9;
    localparam logic [3:0] OP_BIT       = 4'hB;
    localparam logic [1:0] AS_REG       = 2'h0;
    localparam logic [1:0] AS_IDX       = 2'h1;
    localparam logic [1:0] AS_IND       = 2'h2;
    localparam logic [1:0] AS_INC       = 2'h3;
    localparam logic [3:0] REG_PC       = 4'h0;
    localparam logic [3:0] REG_SR       = 4'h2;
    localparam logic [3:0] REG_CG       = 4'h3;
    localparam int         EXT_OP_HI    = 15;
    localparam int         EXT_OP_LO    = 11;
    localparam int         EXT_CF_BIT   = 8;
    localparam int         EXT_REP_BIT  = 7;
    localparam int         EXT_AL_BIT   = 6;
    localparam int         EXT_SRC_HI   = 10;
    localparam int         EXT_SRC_LO   = 7;
    localparam int         BW_BIT       = 6;
    localparam int         AD_BIT       = 7;
    // Cycle counts and lengths in words
    localparam logic [2:0] CYC_1 = 3'h1;
    localparam logic [2:0] CYC_2 = 3'h2;
    localparam logic [2:0] CYC_3 = 3'h3;
    localparam logic [2:0] CYC_4 = 3'h4;
    localparam logic [2:0] CYC_5 = 3'h5;
    localparam logic [2:0] CYC_6 = 3'h6;
    localparam logic [1:0] LEN_1 = 2'h1;
    localparam logic [1:0] LEN_2 = 2'h2;
    localparam logic [1:0] LEN_3 = 2'h3;
    // Operand width codes {length ext, byte/word}
    localparam logic [1:0] WIDTH_WORD = 2'h2;
    // Register map and bus answers
    localparam logic [3:0] ADDR_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_STATUS  = 4'h4;
    localparam logic [3:0] ADDR_LAST    = 4'h8;
    localparam logic [3:0] ADDR_RETIRED = 4'hC;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_DECERR  = 2'h3;
    localparam logic       CTRL_RESET   = 1'h1;
    typedef enum logic [1:0] {
        CCD_IDLE = 2'b01,
        CCD_EXEC = 2'b10
    } ccd_state_t;
endpackage
`default_nettype wire

// ==== verification/ccd_core_model.sv ====
`default_nettype none
// Register file and status carry as the execute stage presents them
module ccd_core_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       carry_set,
    input  wire logic [3:0] rep_reg_sel,
    output logic [3:0]      rep_reg_value,
    output logic            carry_status
);
    timeunit 1ns;
    timeprecision 1ps;

    // Each register's low nibble is its number plus one, so a wrong
    // register select shows up as a wrong repeat count
    assign rep_reg_value = rep_reg_sel + 4'h1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            carry_status <= 1'b0;
        end else begin
            carry_status <= carry_set;
        end
    end
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ccd_pkg::*;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        instr_valid = 1'b0;
    logic        carry_set = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [3:0]  rep_reg_value, rep_reg_sel, src_hi, dst_hi;
    logic        instr_ready, done, ext_addr20, ext_noprefix;
    logic        carry_force_select, carry_status, carry_use;
    logic [1:0]  done_len, width_sel, bresp, rresp, o_w, rs;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, o_s, o_d;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic        o_x, o_c, o_n, o_f;
    int          err_count = 0;
    int          checks_done = 0;
    int          retired = 0;
    logic [15:0] fw [20];
    int          fc [20];
    logic [1:0]  fl [20];

    always #20 clk = ~clk;

    ccd_decoder ccd_decoder_i (
        .clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .rep_reg_value(rep_reg_value),
        .carry_status(carry_status), .instr_ready(instr_ready),
        .done(done), .done_len(done_len), .ext_addr20(ext_addr20),
        .ext_noprefix(ext_noprefix), .width_sel(width_sel),
        .carry_force_select(carry_force_select), .carry_use(carry_use),
        .rep_reg_sel(rep_reg_sel), .src_hi(src_hi), .dst_hi(dst_hi),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp)
    );

    ccd_core_model ccd_core_model_i (
        .clk(clk), .rst_n(rst_n), .carry_set(carry_set),
        .rep_reg_sel(rep_reg_sel), .rep_reg_value(rep_reg_value),
        .carry_status(carry_status)
    );

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // Valid stays up on return so a prefix and its instruction go back
    // to back without a second assignment in one time step
    task automatic feed(input logic [15:0] w);
        instr_valid <= 1'b1;
        instr_word  <= w;
        do @(posedge clk); while (instr_ready !== 1'b1);
    endtask

    task automatic run(input logic [15:0] w, input int cyc,
                       input logic [1:0] len);
        int n;
        n = 0;
        feed(w);
        instr_valid <= 1'b0;
        do begin
            @(posedge clk);
            n++;
            if (n == 1) begin
                {o_x, o_w, o_c, o_n, o_s, o_d, o_f} = {ext_addr20,
                    width_sel, carry_use, ext_noprefix, src_hi, dst_hi,
                    carry_force_select};
            end
        end while (done !== 1'b1 && n < 300);
        retired++;
        chk("cycles", n - 1, cyc);
        chk("length", done_len, len);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        finish_test();
    end

    initial begin
        fw = '{16'h3C00, 16'h2000, 16'h5506, 16'h5500, 16'h5586, 16'h5526,
               16'h5520, 16'h55B6, 16'h5536, 16'h5036, 16'h5030, 16'h50B6,
               16'h5516, 16'h5510, 16'h5596, 16'h5216, 16'h5096, 16'h4596,
               16'h9596, 16'hB586};
        fc = '{2, 2, 1, 2, 4, 2, 3, 5, 2, 2, 3, 5, 3, 3, 6, 3, 6, 5, 5, 3};
        fl = '{1, 1, 1, 1, 2, 1, 1, 2, 1, 2, 2, 3, 2, 2, 3, 2, 3, 3, 3, 2};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        // Internal reset lets go two edges later
        repeat (2) @(posedge clk);
        rd_reg(ADDR_CTRL);
        chk("ctrl", rd, 32'h1);
        for (int i = 0; i < 20; i++) begin
            run(fw[i], fc[i], fl[i]);
        end
        carry_set <= 1'b1;
        feed(16'h1843);
        run(16'h5506, 4, 2'h1);
        chk("x20", o_x, 1'b1);
        chk("width", o_w, 2'h2);
        chk("carry", o_c, 1'b1);
        chk("cforce", o_f, 1'b0);
        chk("dsthi", o_d, 4'h0);
        feed(16'h1E43);
        run(16'h5506, 4, 2'h1);
        // R2 holds 3 in the model, so four passes
        feed(16'h1982);
        run(16'h5546, 4, 2'h1);
        chk("width", o_w, 2'h1);
        chk("carry", o_c, 1'b0);
        chk("cforce", o_f, 1'b1);
        feed(16'h1D45);
        run(16'h5596, 6, 2'h3);
        chk("srchi", o_s, 4'hA);
        chk("dsthi", o_d, 4'h5);
        chk("cforce", o_f, 1'b0);
        rd_reg(ADDR_LAST);
        chk("last", {rd[9:8], rd[2:0]}, 5'h1E);
        run(16'h5506, 1, 2'h1);
        chk("x20", o_x, 1'b0);
        chk("width", o_w, 2'h2);
        chk("noprefix", o_n, 1'b0);
        run(16'h0180, 1, 2'h1);
        chk("noprefix", o_n, 1'b1);
        rd_reg(ADDR_RETIRED);
        chk("retired", rd, retired);
        wr(ADDR_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        chk("ready", instr_ready, 1'b0);
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_RETIRED, 32'h0);
        chk("bresp", rs, RESP_OKAY);
        rd_reg(ADDR_RETIRED);
        chk("retired", rd, retired);
        rd_reg(4'h2);
        chk("rresp", rs, RESP_DECERR);
        chk("rdata", rd, 32'h0);
        run(16'h3C00, 2, 2'h1);
        finish_test();
    end
endmodule
`default_nettype wire
